// ==== rtl/ucg_clock_gen.sv ====
// Purpose: Fractional rate generator and transfer-clock handling of a serial port
// Assumes: Inputs other than xfer_clk_in synchronous to clk_in, AHB-Lite single word transfers
// Notes: Emits sample, shift and capture enable pulses to the serial engines
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`include "ucg_defines.svh"

// Functional notes
// - Five modes: async normal, async double, sync master, sync slave, SPI master.
// - Async divisor: upper ten bits integer, lower six bits fraction.
// - Fraction shifts each bit's sampling instant, averaging out integer error.
// - Sync modes use only integer part; fraction written as zero.
// - Rate is clock times 64 over samples per bit times divisor.
// - Sixteen samples per symbol normally, eight in double speed.
// - Double speed doubles async rate with half the samples.
// - Slave transfer clock sampled by peripheral clock, below quarter rate.
// - Transfer clock driven in master mode, input in slave mode.
// - Receive sampled on edge opposite the transmit change edge.
// - No inversion: change rising, sample falling; inverted: reverse.
// - SPI master uses internal generator like sync master.
// - SPI mode is inversion times two plus phase, edges per table.
// - SPI shifts and latches on opposite edges; no change mid-transfer.
// - Open-drain enable makes one-wire data pin wired-AND.
module ucg_clock_gen #(
  parameter int INT_W = `UCG_INT_W,
  parameter int FRAC_W = `UCG_FRAC_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Transfer clock pin
  input wire logic xfer_clk_in,
  output logic xfer_clk_out,
  output logic xfer_clk_oe_out,
  // Shared data pin in one-wire mode
  input wire logic tx_data_in,
  input wire logic tx_enable_in,
  output logic data_pin_out,
  output logic data_pin_oe_out,
  // Timing pulses to the engines
  output logic sample_tick_out,
  output logic shift_tick_out,
  output logic capture_tick_out
);
  localparam int DW = INT_W + FRAC_W;

  typedef struct packed {
    logic [DW-1:0] divisor;
    logic [7:0] control;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic [INT_W-1:0] int_cnt;
    logic [FRAC_W:0] frac_acc;
    logic extra;
    logic [4:0] sub_cnt;
    logic xclk;
    logic sync1;
    logic sync2;
    logic sync3;
    logic sample;
    logic shift;
    logic capture;
    logic pin;
    logic pin_oe;
    logic xclk_pin;
    logic clk_oe;
  } ucg_state_t;

  ucg_state_t s_q, s_d;

  function automatic ucg_pkg::ucg_mode_t decode_mode(input logic [7:0] c);
    case (c[`UCG_CTL_MODE_LSB +: 3])
      3'h0: decode_mode = ucg_pkg::UCG_ASYNC;
      3'h1: decode_mode = ucg_pkg::UCG_SYNC_MASTER;
      3'h2: decode_mode = ucg_pkg::UCG_SYNC_SLAVE;
      3'h3: decode_mode = ucg_pkg::UCG_SPI_MASTER;
      default: decode_mode = ucg_pkg::UCG_OFF;
    endcase
  endfunction

  ucg_pkg::ucg_mode_t mode;
  logic async_mode, master_sync, base_tick, lead_edge, trail_edge, xclk_rise, xclk_fall;
  logic [4:0] spb;
  logic [INT_W-1:0] int_part;
  logic [FRAC_W-1:0] frac_part;

  always_comb
  begin
    mode = decode_mode(s_q.control);
    async_mode = (mode == ucg_pkg::UCG_ASYNC);
    master_sync = (mode == ucg_pkg::UCG_SYNC_MASTER) || (mode == ucg_pkg::UCG_SPI_MASTER);
    int_part = s_q.divisor[DW-1:FRAC_W];
    frac_part = async_mode ? s_q.divisor[FRAC_W-1:0] : '0;
    if (!async_mode)
      spb = `UCG_SPB_SYNC;
    else if (s_q.control[`UCG_CTL_DOUBLE])
      spb = `UCG_SPB_DOUBLE;
    else
      spb = `UCG_SPB_NORMAL;
    base_tick = (mode != ucg_pkg::UCG_OFF) && (mode != ucg_pkg::UCG_SYNC_SLAVE)
      && (s_q.int_cnt == '0) && !s_q.extra;
    xclk_rise = s_q.sync2 && !s_q.sync3;
    xclk_fall = !s_q.sync2 && s_q.sync3;
  end

  always_comb
  begin
    s_d = s_q;
    s_d.sample = 1'b0;
    s_d.shift = 1'b0;
    s_d.capture = 1'b0;
    lead_edge = 1'b0;
    trail_edge = 1'b0;
    // Bus write data phase
    if (s_q.wr_pend)
    begin
      s_d.wr_pend = 1'b0;
      if (s_q.wr_addr == `UCG_OFF_DIVISOR)
        s_d.divisor = hwdata_in[DW-1:0];
      else if (s_q.wr_addr == `UCG_OFF_CONTROL)
        s_d.control = hwdata_in[7:0];
    end
    // Bus address phase
    if (hsel_in && hready_in && htrans_in[1])
    begin
      s_d.wr_pend = hwrite_in;
      s_d.wr_addr = haddr_in[7:0];
      case (haddr_in[7:0])
        `UCG_OFF_DIVISOR: s_d.rdata = {{(32-DW){1'b0}}, s_q.divisor};
        `UCG_OFF_CONTROL: s_d.rdata = {24'h000000, s_q.control};
        `UCG_OFF_STATUS: s_d.rdata = {29'h00000000, s_q.xclk, s_q.sync2, s_q.extra};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    // Rate generator: integer counter with fractional stretch
    if (s_q.extra)
      s_d.extra = 1'b0;
    else if (s_q.int_cnt != '0)
      s_d.int_cnt = s_q.int_cnt - 1'b1;
    if (base_tick)
    begin
      s_d.int_cnt = (int_part > 1) ? int_part - 1'b1 : '0;
      s_d.frac_acc = {1'b0, s_q.frac_acc[FRAC_W-1:0]} + {1'b0, frac_part};
      s_d.extra = s_d.frac_acc[FRAC_W];
      if (s_q.sub_cnt >= spb - 1'b1)
        s_d.sub_cnt = '0;
      else
        s_d.sub_cnt = s_q.sub_cnt + 1'b1;
      if (async_mode)
      begin
        s_d.sample = 1'b1;
        s_d.shift = (s_q.sub_cnt == '0);
      end
      else
      begin
        s_d.xclk = ~s_q.xclk;
        lead_edge = !s_q.xclk;
        trail_edge = s_q.xclk;
      end
    end
    // Slave clock sampled with the peripheral clock
    s_d.sync1 = xfer_clk_in;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    if (mode == ucg_pkg::UCG_SYNC_SLAVE)
    begin
      lead_edge = s_q.control[`UCG_CTL_INVERT] ? xclk_fall : xclk_rise;
      trail_edge = s_q.control[`UCG_CTL_INVERT] ? xclk_rise : xclk_fall;
    end
    // Edge roles: in SPI master, phase picks sample or setup on leading edge
    if (!async_mode && mode != ucg_pkg::UCG_OFF)
    begin
      if (mode == ucg_pkg::UCG_SPI_MASTER && !s_q.control[`UCG_CTL_PHASE])
      begin
        s_d.capture = lead_edge;
        s_d.shift = trail_edge;
      end
      else
      begin
        s_d.shift = lead_edge;
        s_d.capture = trail_edge;
      end
    end
    // Shared data pin, wired-AND when open drain and one-wire are both set
    if (s_q.control[`UCG_CTL_ODRAIN] && s_q.control[`UCG_CTL_ONEWIRE])
    begin
      s_d.pin = 1'b0;
      s_d.pin_oe = tx_enable_in && !tx_data_in;
    end
    else
    begin
      s_d.pin = tx_data_in;
      s_d.pin_oe = tx_enable_in;
    end
    // Transfer clock pin level and drive enable, registered
    s_d.xclk_pin = s_d.xclk ^ s_d.control[`UCG_CTL_INVERT];
    s_d.clk_oe = (s_d.control[2:0] == 3'h1) || (s_d.control[2:0] == 3'h3);
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_q <= '0;
      s_q.divisor <= `UCG_DIVISOR_RST;
      s_q.pin <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Transfer clock pin polarity follows the invert bit
  assign xfer_clk_out = s_q.xclk_pin;
  assign xfer_clk_oe_out = s_q.clk_oe;
  assign data_pin_out = s_q.pin;
  assign data_pin_oe_out = s_q.pin_oe;
  assign hrdata_out = s_q.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign sample_tick_out = s_q.sample;
  assign shift_tick_out = s_q.shift;
  assign capture_tick_out = s_q.capture;

  a_slave_no_out: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_q.control[2:0] == 3'h2) |-> !xfer_clk_oe_out)
    else $error("Transfer clock driven in slave mode");
  a_master_drives: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_q.control[2:0] == 3'h1) |-> xfer_clk_oe_out)
    else $error("Transfer clock not driven in master mode");
  a_edges_apart: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !(shift_tick_out && capture_tick_out))
    else $error("Shift and capture on the same edge");
  a_slave_sample: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode == ucg_pkg::UCG_SYNC_SLAVE && !s_q.control[4] && s_q.sync2 && !s_q.sync3)
    |=> shift_tick_out)
    else $error("Slave rising edge gave no shift");
  a_frac_stretch: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_q.extra |=> !sample_tick_out)
    else $error("Stretch cycle produced a tick");
  a_async_div: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (async_mode && base_tick && int_part == 10'h001 && frac_part == '0 && !s_q.wr_pend
      && $stable(s_q.divisor)) |=> sample_tick_out ##1 sample_tick_out)
    else $error("Divisor one does not tick every cycle");
  a_sync_no_frac: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!async_mode && base_tick) |=> !s_q.extra)
    else $error("Fraction used in synchronous mode");
  a_odrain_high: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_q.control[6] && s_q.control[7]) |=> !data_pin_out)
    else $error("Open drain pin drives high");

  // Mode, edge and data pin checks
  a_async_no_cap: assert property (@(posedge clk_in) disable iff (!resetn_in)
    async_mode |=> !capture_tick_out)
    else $error("Capture tick in asynchronous mode");
  a_off_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode == ucg_pkg::UCG_OFF) |=> !(sample_tick_out || shift_tick_out || capture_tick_out))
    else $error("Tick while the generator is off");
  a_sync_no_sample: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !async_mode |=> !sample_tick_out)
    else $error("Oversample tick in synchronous mode");
  a_slave_fall_cap: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode == ucg_pkg::UCG_SYNC_SLAVE && !s_q.control[`UCG_CTL_INVERT] && xclk_fall)
    |=> capture_tick_out)
    else $error("Slave falling edge gave no capture");
  a_slave_inv_cap: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode == ucg_pkg::UCG_SYNC_SLAVE && s_q.control[`UCG_CTL_INVERT] && xclk_rise)
    |=> capture_tick_out)
    else $error("Inverted slave rising edge gave no capture");
  a_master_lead: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode == ucg_pkg::UCG_SYNC_MASTER && base_tick && !s_q.xclk) |=> shift_tick_out)
    else $error("Master leading edge gave no shift");
  a_spi_phase0: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode == ucg_pkg::UCG_SPI_MASTER && !s_q.control[`UCG_CTL_PHASE] && base_tick
      && !s_q.xclk) |=> capture_tick_out)
    else $error("SPI phase zero leading edge gave no capture");
  a_spi_phase1: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode == ucg_pkg::UCG_SPI_MASTER && s_q.control[`UCG_CTL_PHASE] && base_tick
      && !s_q.xclk) |=> shift_tick_out)
    else $error("SPI phase one leading edge gave no shift");
  a_xclk_toggle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!async_mode && base_tick) |=> (s_q.xclk != $past(s_q.xclk)))
    else $error("Internal transfer clock did not toggle");
  a_od_no_drive: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_q.control[6] && s_q.control[7] && tx_enable_in && tx_data_in) |=> !data_pin_oe_out)
    else $error("Open drain pin driven for a high bit");
  a_plain_pin: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !(s_q.control[6] && s_q.control[7]) |=> (data_pin_out == $past(tx_data_in)))
    else $error("Data pin does not follow transmit data");
endmodule // ucg_clock_gen

// ==== rtl/ucg_defines.svh ====
// Purpose: Offsets, fields, reset values and timing counts of the clock generator
// Assumes: 32-bit AHB-Lite register words
// Notes: Included by the top module
`ifndef UCG_DEFINES_SVH
`define UCG_DEFINES_SVH
`define UCG_OFF_DIVISOR 8'h00
`define UCG_OFF_CONTROL 8'h04
`define UCG_OFF_STATUS 8'h08
`define UCG_DIVISOR_RST 16'h0040
`define UCG_FRAC_W 6
`define UCG_INT_W 10
`define UCG_SPB_NORMAL 5'h10
`define UCG_SPB_DOUBLE 5'h08
`define UCG_SPB_SYNC 5'h02
`define UCG_CTL_MODE_LSB 0
`define UCG_CTL_DOUBLE 3
`define UCG_CTL_INVERT 4
`define UCG_CTL_PHASE 5
`define UCG_CTL_ODRAIN 6
`define UCG_CTL_ONEWIRE 7
`endif

// ==== rtl/ucg_pkg.sv ====
// Purpose: Types of the clock generator
// Assumes: Nothing
// Notes: Constants live in ucg_defines.svh
package ucg_pkg;
  typedef enum logic [2:0] {
    UCG_ASYNC,
    UCG_SYNC_MASTER,
    UCG_SYNC_SLAVE,
    UCG_SPI_MASTER,
    UCG_OFF
  } ucg_mode_t;
endpackage

// ==== verification/ucg_peer.sv ====
// Purpose: Serial peer that drives the transfer clock in slave mode
// Assumes: Half period of at least two peripheral clocks
// Notes: Clock stands low outside frames
`timescale 1ns/10ps
module ucg_peer (
  // Clock and control
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic [3:0] half_in,
  // Transfer clock
  output logic xclk_out
);
  logic [3:0] cnt_q = 4'h0;
  initial xclk_out = 1'b0;
  always @(posedge clk_in)
  begin
    cnt_q <= (cnt_q + 4'h1 >= half_in) ? 4'h0 : cnt_q + 4'h1;
    if (!run_in)
    begin
      xclk_out <= 1'b0;
      cnt_q <= 4'h0;
    end
    else if (cnt_q + 4'h1 >= half_in)
      xclk_out <= ~xclk_out;
  end
endmodule // ucg_peer

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench of the clock generator
// Assumes: Zero-wait AHB-Lite slave
// Notes: Read data and tick gaps are checked against queued notes
`timescale 1ns/10ps
module testbench;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, txd = 1'b1, txe = 1'b0, rdp = 1'b0, run = 1'b0, gsel = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic hready, hresp, xout, xoe, pxc, dout, doe, st, sh, ct, pin, inv, ph, od;
  logic [31:0] rd_q[$];
  logic [8:0] gap_q[$];
  logic [7:0] cnt = 8'h0;
  int bad_count = 0, check_count = 0, i, m;
  assign pin = xoe ? xout : pxc;
  always #5 clk_in = ~clk_in;
  ucg_clock_gen ucg_clock_gen_inst (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .xfer_clk_in(pin), .xfer_clk_out(xout), .xfer_clk_oe_out(xoe),
    .tx_data_in(txd), .tx_enable_in(txe), .data_pin_out(dout), .data_pin_oe_out(doe),
    .sample_tick_out(st), .shift_tick_out(sh), .capture_tick_out(ct));
  ucg_peer ucg_peer_inst (.clk_in(clk_in), .run_in(run), .half_in(4'h5), .xclk_out(pxc));
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stall();
    bad_count++;
    report_and_stop();
  endtask
  task automatic rdy();
    i = 0;
    do @(posedge clk_in); while (hready !== 1'b1 && ++i < 64);
    if (i >= 64)
      stall();
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdp <= !w;
    rdy();
    rdp <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask
  task automatic cfg(input logic [31:0] dv, input logic [31:0] c);
    ahb(1'b1, 32'h0, dv);
    ahb(1'b1, 32'h4, c);
  endtask
  task automatic gaps(input logic s, input logic l, input logic [7:0] g);
    gsel <= s;
    repeat (2) gap_q.push_back(9'h1ff);
    repeat (4) gap_q.push_back({l, g});
    for (i = 0; i < 2000 && gap_q.size() > 0; i++)
      @(posedge clk_in);
    if (gap_q.size() > 0)
      stall();
  endtask
  always @(posedge clk_in)
    if (rdp && hready === 1'b1)
    begin
      cmp("hrdata", rd_q.pop_front(), hrdata);
      cmp("hresp", 32'h0, hresp);
    end
  always @(posedge clk_in)
  begin
    cnt <= cnt + 8'h1;
    if ((gsel ? ct : sh) === 1'b1)
    begin
      cnt <= 8'h1;
      if (gap_q.size() > 0 && gap_q[0] == 9'h1ff)
        void'(gap_q.pop_front());
      else if (gap_q.size() > 0)
        cmp("tick gap", gap_q.pop_front(), {gsel & pin, cnt});
    end
  end
  initial
  begin
    i = $urandom(67);
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(32'h0, 32'h40);
    rd(32'h4, 32'h0);
    ahb(1'b1, 32'hc, 32'hffffffff);
    rd(32'hc, 32'h0);
    r = $urandom & 32'hffff;
    ahb(1'b1, 32'h0, r);
    rd(32'h0, r);
    cfg(32'h100, 32'h0);
    gaps(1'b0, 1'b0, 8'h40);
    cfg(32'h100, 32'h8);
    gaps(1'b0, 1'b0, 8'h20);
    cfg(32'h120, 32'h0);
    gaps(1'b0, 1'b0, 8'h48);
    cfg(32'h40, 32'h0);
    gaps(1'b0, 1'b0, 8'h10);
    for (m = 0; m < 4; m++)
    begin
      inv = m[1];
      ph = m[0];
      cfg(32'h100, 32'h1 | (inv << 4));
      gaps(1'b1, inv, 8'h08);
      cfg(32'h100, 32'h3 | (inv << 4) | (ph << 5));
      gaps(1'b1, ~(inv ^ ph), 8'h08);
      cmp("clock oe", 32'h1, xoe);
    end
    run <= 1'b1;
    for (m = 0; m < 2; m++)
    begin
      inv = m[0];
      cfg(32'h100, 32'h2 | (inv << 4));
      gaps(1'b1, inv, 8'h0a);
      cmp("clock oe", 32'h0, xoe);
    end
    run <= 1'b0;
    txe <= 1'b1;
    for (m = 0; m < 8; m++)
    begin
      od = m[0];
      cfg(32'h100, 32'h80 | (od << 6));
      txd <= $urandom & 1;
      repeat (4) @(posedge clk_in);
      cmp("data pin", od ? {~txd, 1'b0} : {1'b1, txd}, {doe, doe & dout});
    end
    report_and_stop();
  end
endmodule // testbench
